/* File: mma_defs.svh */
// constants for the micromirror array memory loader
// Overview of operation
// R1 - cell store of 912 columns by 1140 rows
// R2 - columns load over 24-bit double-data-rate bus
// R3 - column choice travels on serial control bus
// R4 - mirrors move only at clocking pulse
// R5 - cell one lands mirror at plus twelve
// R6 - cell zero lands mirror at minus twelve
// R7 - controller writes cells, then pulses whole array
// R8 - pulses made inside, controller starts them
// R9 - ten border mirrors unwritable, land off
// R10 - controller maps data for diamond layout
// R11 - parked mirrors hold no latched position
// R12 - streaming mode: unlimited patterns, 2880 Hz
// R13 - burst mode: 48 patterns, 4220 Hz
// R14 - unwritten cells keep contents across pulses
`ifndef MMA_DEFS_SVH
`define MMA_DEFS_SVH
`define MMA_COLS 912
`define MMA_ROWS 1140
`define MMA_BUS_W 24
`define MMA_WPC 48
`define MMA_LAST_BITS 12
`define MMA_WORDS 43776
`define MMA_BORDER 10
`define MMA_FIFO_DEPTH 16
`define MMA_CMD_BITS 16
`define MMA_OP_MSB 15
`define MMA_OP_LSB 14
`define MMA_OP_COL 2'h0
`define MMA_OP_PULSE 2'h1
`define MMA_OP_PARK 2'h2
`define MMA_RST_ADDR 16'h0000
`endif

/* File: mma_pkg.sv */
// types shared by the micromirror array memory loader
package mma_pkg;
  typedef logic [23:0] mma_word_t;
  typedef logic [9:0] mma_col_t;
  typedef logic [15:0] mma_addr_t;
  typedef enum logic [1:0] {ST_PARKED, ST_IDLE, ST_SWEEP} mma_state_e;
endpackage : mma_pkg

/* File: mma_loader.sv */
// micromirror array cell store, column loader, command decoder and mirror latch
`timescale 1ns/10ps
`include "mma_defs.svh"

module mma_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  // handshakes from the fill level
  assign o_ready = (count != (AW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = store[rd_ptr];

  // pointer and level update
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage write
  always_ff @(posedge i_clk) begin
    if (push) begin
      store[wr_ptr] <= i_data;
    end
  end

  property p_fifo_level;
    @(posedge i_clk) disable iff (!i_arst_n)
    count <= (AW+1)'(DEPTH);
  endproperty
  a_fifo_level: assert property (p_fifo_level) else $error("fifo level above depth");

  property p_fifo_full_stalls;
    @(posedge i_clk) disable iff (!i_arst_n)
    (count == (AW+1)'(DEPTH)) |-> !o_ready;
  endproperty
  a_fifo_full_stalls: assert property (p_fifo_full_stalls) else $error("full fifo takes data");
endmodule : mma_fifo

module mma_loader (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_dclk,
  input wire logic [23:0] i_data,
  input wire logic i_sclk,
  input wire logic i_sdi,
  input wire logic i_scs_n,
  input wire logic [9:0] i_probe_col,
  input wire logic [5:0] i_probe_word,
  output logic o_fifo_ready,
  output logic o_pulse_busy,
  output logic o_landed,
  output logic [23:0] o_mirror_word,
  output logic o_border_on
);
  // cell store and latched mirror states, one bit per cell R1
  mma_pkg::mma_word_t cell_mem [`MMA_WORDS];
  mma_pkg::mma_word_t mirror_mem [`MMA_WORDS];

  // two-flop synchronisers for the data and serial bus pins, not the probe inputs
  logic dclk_s1, dclk_s2, dclk_d;
  logic [23:0] data_s1, data_s2;
  logic sclk_s1, sclk_s2, sclk_d;
  logic sdi_s1, sdi_s2;
  logic scs_s1, scs_s2, scs_d;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dclk_s1 <= 1'b0;
      dclk_s2 <= 1'b0;
      dclk_d <= 1'b0;
      data_s1 <= 24'h000000;
      data_s2 <= 24'h000000;
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d <= 1'b0;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
      scs_s1 <= 1'b1;
      scs_s2 <= 1'b1;
      scs_d <= 1'b1;
    end else begin
      dclk_s1 <= i_dclk;
      dclk_s2 <= dclk_s1;
      dclk_d <= dclk_s2;
      data_s1 <= i_data;
      data_s2 <= data_s1;
      sclk_s1 <= i_sclk;
      sclk_s2 <= sclk_s1;
      sclk_d <= sclk_s2;
      sdi_s1 <= i_sdi;
      sdi_s2 <= sdi_s1;
      scs_s1 <= i_scs_n;
      scs_s2 <= scs_s1;
      scs_d <= scs_s2;
    end
  end

  // a word on each data clock edge, both edges
  logic ddr_strobe;
  assign ddr_strobe = dclk_s2 ^ dclk_d; // R2

  // column data buffer
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  mma_pkg::mma_word_t fifo_out;
  mma_fifo #(.WIDTH(`MMA_BUS_W), .DEPTH(`MMA_FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_valid(ddr_strobe),
    .o_ready(fifo_in_ready),
    .i_data(data_s2),
    .o_valid(fifo_out_valid),
    .i_ready(fifo_pop),
    .o_data(fifo_out)
  );
  assign o_fifo_ready = fifo_in_ready;

  // serial control frame shifter
  logic [15:0] shreg, next_shreg;
  logic [4:0] bitcnt, next_bitcnt;
  logic cmd_go;
  always_comb begin
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    if (scs_s2) begin
      next_bitcnt = 5'h00;
    end else if (sclk_s2 && !sclk_d) begin
      next_shreg = {shreg[14:0], sdi_s2}; // R3
      next_bitcnt = (bitcnt == 5'h1F) ? bitcnt : bitcnt + 5'h01;
    end
  end
  assign cmd_go = scs_s2 && !scs_d && (bitcnt == 5'(`MMA_CMD_BITS));

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shreg <= 16'h0000;
      bitcnt <= 5'h00;
    end else begin
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
    end
  end

  // column pointer, word pointer and mirror pulse sequencer
  mma_pkg::mma_state_e state, next_state;
  mma_pkg::mma_col_t col_sel, next_col_sel;
  logic [5:0] word_idx, next_word_idx;
  mma_pkg::mma_addr_t sweep_addr, next_sweep_addr;
  mma_pkg::mma_addr_t wr_addr;
  logic [1:0] cmd_op;
  logic sweep_last;
  assign cmd_op = shreg[`MMA_OP_MSB:`MMA_OP_LSB];
  assign sweep_last = (sweep_addr == 16'(`MMA_WORDS - 1));
  // writes stall during a sweep so no cell changes under it
  assign fifo_pop = fifo_out_valid && (state != mma_pkg::ST_SWEEP);
  assign wr_addr = 16'(col_sel) * 16'(`MMA_WPC) + 16'(word_idx);

  always_comb begin
    next_state = state;
    next_col_sel = col_sel;
    next_word_idx = word_idx;
    next_sweep_addr = sweep_addr;
    if (fifo_pop) begin
      if (word_idx == 6'(`MMA_WPC - 1)) begin
        next_word_idx = 6'h00;
        next_col_sel = (col_sel == 10'(`MMA_COLS - 1)) ? 10'h000 : col_sel + 10'h001;
      end else begin
        next_word_idx = word_idx + 6'h01;
      end
    end
    unique case (state)
      mma_pkg::ST_PARKED, mma_pkg::ST_IDLE: begin
        if (cmd_go && cmd_op == `MMA_OP_PULSE) begin
          next_state = mma_pkg::ST_SWEEP; // R8
          next_sweep_addr = `MMA_RST_ADDR;
        end else if (cmd_go && cmd_op == `MMA_OP_PARK) begin
          next_state = mma_pkg::ST_PARKED; // R11
        end else if (cmd_go && cmd_op == `MMA_OP_COL) begin
          if (shreg[9:0] < 10'(`MMA_COLS)) begin
            next_col_sel = shreg[9:0]; // R3
            next_word_idx = 6'h00;
          end
        end
      end
      mma_pkg::ST_SWEEP: begin
        next_sweep_addr = sweep_addr + 16'h0001;
        if (sweep_last) begin
          next_state = mma_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= mma_pkg::ST_PARKED;
      col_sel <= 10'h000;
      word_idx <= 6'h00;
      sweep_addr <= `MMA_RST_ADDR;
    end else begin
      state <= next_state;
      col_sel <= next_col_sel;
      word_idx <= next_word_idx;
      sweep_addr <= next_sweep_addr;
    end
  end

  // cell write; bits past the last row do not exist
  mma_pkg::mma_word_t wr_word;
  assign wr_word = (word_idx == 6'(`MMA_WPC - 1)) ?
    {12'h000, fifo_out[`MMA_LAST_BITS-1:0]} : fifo_out;
  always_ff @(posedge i_clk) begin
    if (fifo_pop) begin
      cell_mem[wr_addr] <= wr_word; // R2 R14
    end
  end

  // mirror latch copies cells only during a pulse sweep
  always_ff @(posedge i_clk) begin
    if (state == mma_pkg::ST_SWEEP) begin
      mirror_mem[sweep_addr] <= cell_mem[sweep_addr]; // R4 R7
    end
  end

  // landed state readback: 1 is plus twelve, 0 minus twelve
  mma_pkg::mma_word_t next_mirror_word;
  logic next_landed;
  mma_pkg::mma_addr_t probe_addr;
  assign probe_addr = 16'(i_probe_col) * 16'(`MMA_WPC) + 16'(i_probe_word);
  always_comb begin
    next_landed = (state != mma_pkg::ST_PARKED); // R11
    next_mirror_word = next_landed ? mirror_mem[probe_addr] : 24'h000000; // R5 R6
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_landed <= 1'b0;
      o_mirror_word <= 24'h000000;
    end else begin
      o_landed <= next_landed;
      o_mirror_word <= next_mirror_word;
    end
  end

  assign o_pulse_busy = (state == mma_pkg::ST_SWEEP);
  // border band has no write path and always lands off
  assign o_border_on = 1'b0; // R9

  // sweep length counter for checking
  logic [15:0] sweep_len;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sweep_len <= 16'h0000;
    end else begin
      sweep_len <= o_pulse_busy ? sweep_len + 16'h0001 : 16'h0000;
    end
  end

  sequence s_pulse_cmd;
    cmd_go && cmd_op == `MMA_OP_PULSE && state != mma_pkg::ST_SWEEP;
  endsequence
  sequence s_sweep_start;
    o_pulse_busy && sweep_addr == `MMA_RST_ADDR;
  endsequence

  property p_pulse_starts;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_pulse_cmd |=> s_sweep_start;
  endproperty
  a_pulse_starts: assert property (p_pulse_starts) else $error("pulse did not start"); // R8

  property p_sweep_bounded;
    @(posedge i_clk) disable iff (!i_arst_n)
    sweep_len <= 16'(`MMA_WORDS);
  endproperty
  a_sweep_bounded: assert property (p_sweep_bounded) else $error("sweep too long"); // R7

  property p_no_write_in_sweep;
    @(posedge i_clk) disable iff (!i_arst_n)
    o_pulse_busy |-> !fifo_pop;
  endproperty
  a_no_write_in_sweep: assert property (p_no_write_in_sweep) else $error("write in sweep"); // R4

  property p_parked_reads_zero;
    @(posedge i_clk) disable iff (!i_arst_n)
    (state == mma_pkg::ST_PARKED) |=> (!o_landed && o_mirror_word == 24'h000000);
  endproperty
  a_parked_reads_zero: assert property (p_parked_reads_zero) else $error("parked shows tilt"); // R11

  property p_col_range;
    @(posedge i_clk) disable iff (!i_arst_n)
    col_sel < 10'(`MMA_COLS) && word_idx < 6'(`MMA_WPC);
  endproperty
  a_col_range: assert property (p_col_range) else $error("column pointer out of range"); // R1

  property p_word_wrap;
    @(posedge i_clk) disable iff (!i_arst_n)
    (fifo_pop && word_idx == 6'(`MMA_WPC - 1)) |=> (word_idx == 6'h00);
  endproperty
  a_word_wrap: assert property (p_word_wrap) else $error("column did not wrap"); // R2

  property p_border_off;
    @(posedge i_clk) disable iff (!i_arst_n)
    !o_border_on;
  endproperty
  a_border_off: assert property (p_border_off) else $error("border mirror on"); // R9

  property p_sweep_ends_idle;
    @(posedge i_clk) disable iff (!i_arst_n)
    (o_pulse_busy && sweep_last) |=> (state == mma_pkg::ST_IDLE) ##1 o_landed;
  endproperty
  a_sweep_ends_idle: assert property (p_sweep_ends_idle) else $error("sweep end wrong"); // R4
endmodule : mma_loader

/* File: mma_ctrl_model.sv */
// controller model driving the column data bus and serial control bus
`timescale 1ns/10ps
module mma_ctrl_model (
  input wire logic i_clk,
  output logic o_dclk,
  output logic [23:0] o_data,
  output logic o_sclk,
  output logic o_sdi,
  output logic o_scs_n
);
  // idle: clocks still, frame deselected
  initial begin
    o_dclk = 1'b0;
    o_data = 24'h000000;
    o_sclk = 1'b0;
    o_sdi = 1'b1;
    o_scs_n = 1'b1;
  end
  // one word per bus clock edge, either direction, held around the edge
  // words arrive already mapped for the offset odd rows, streamed without a count limit
  task automatic send_word(input logic [23:0] w);
    o_data = w;
    repeat (2) @(negedge i_clk);
    o_dclk = ~o_dclk;
    repeat (4) @(negedge i_clk);
    o_data = ~w; // hold over, stale value inverted
    @(negedge i_clk);
  endtask : send_word
  // one 16-bit frame, msb first, carries column choice, pulse start or park
  task automatic send_cmd(input logic [15:0] c);
    send_bits(c, 16);
  endtask : send_cmd
  // frame of the top n bits of c, msb first; only 16 bits make a command
  task automatic send_bits(input logic [15:0] c, input int n);
    o_scs_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      o_sdi = c[i];
      repeat (3) @(negedge i_clk);
      o_sclk = 1'b1;
      repeat (3) @(negedge i_clk);
      o_sclk = 1'b0;
    end
    repeat (3) @(negedge i_clk);
    o_scs_n = 1'b1;
    o_sdi = ~o_sdi; // released line shows the last bit inverted
    repeat (4) @(negedge i_clk);
  endtask : send_bits
endmodule : mma_ctrl_model

/* File: micromirror_array_memory_loader_bench.sv */
// self-checking bench for the micromirror array memory loader
`timescale 1ns/10ps
`include "mma_defs.svh"
module micromirror_array_memory_loader_bench;
  logic clk, arst_n, dclk, sclk, sdi, scs_n, fifo_ready, busy, landed, border_on;
  logic [23:0] data;
  mma_pkg::mma_word_t mword;
  logic [9:0] pcol;
  logic [5:0] pword;
  int n_fail = 0;
  int checked = 0;
  int busy_cycles = 0;
  mma_loader dut_u (.i_clk(clk), .i_arst_n(arst_n), .i_dclk(dclk), .i_data(data),
    .i_sclk(sclk), .i_sdi(sdi), .i_scs_n(scs_n), .i_probe_col(pcol), .i_probe_word(pword),
    .o_fifo_ready(fifo_ready), .o_pulse_busy(busy), .o_landed(landed),
    .o_mirror_word(mword), .o_border_on(border_on));
  mma_ctrl_model model_u (.i_clk(clk), .o_dclk(dclk), .o_data(data), .o_sclk(sclk),
    .o_sdi(sdi), .o_scs_n(scs_n));
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // sweep cycles counted at the settled falling edge, even before the command task returns
  always @(negedge clk) begin
    if (busy === 1'b1) begin
      busy_cycles++;
    end
  end
  // compare and count
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  // test pattern per column, word and load pass
  function automatic logic [23:0] pat(input int c, input int w, input int k);
    return {c[7:0] ^ k[7:0], w[7:0], 8'h5A ^ k[7:0]};
  endfunction : pat
  // read one latched mirror word
  task automatic probe(input int c, input int w, output logic [23:0] v);
    pcol = c[9:0];
    pword = w[5:0];
    repeat (2) @(negedge clk);
    v = mword;
  endtask : probe
  // select a column, then stream its 48 words
  task automatic load_col(input int c, input int k);
    model_u.send_cmd({`MMA_OP_COL, 4'h0, c[9:0]});
    for (int w = 0; w < `MMA_WPC; w++) begin
      model_u.send_word(pat(c, w, k));
    end
  endtask : load_col
  // compare a whole column, last word has 12 live bits
  task automatic chk_col(input int c, input int k);
    logic [23:0] v, m;
    for (int w = 0; w < `MMA_WPC; w++) begin
      m = (w == `MMA_WPC - 1) ? 24'h000FFF : 24'hFFFFFF;
      probe(c, w, v);
      chk(v & m, pat(c, w, k) & m, "mirror word");
    end
  endtask : chk_col
  // bounded wait for a busy level
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk({23'h0, busy}, {23'h0, lvl}, "busy level");
  endtask : wait_busy
  // start a pulse, time the sweep, optionally fill the buffer to its depth meanwhile
  // each pulse shows one pattern, far below the burst limit
  task automatic do_pulse(input bit fill);
    int n;
    busy_cycles = 0;
    model_u.send_cmd({`MMA_OP_PULSE, 14'h0000});
    wait_busy(1'b1, 10);
    n = 0;
    if (fill) begin
      for (int w = 0; w < `MMA_FIFO_DEPTH; w++) begin
        model_u.send_word(pat(6, w, 4));
      end
      chk({23'h0, fifo_ready}, 24'h000000, "buffer not full");
    end
    while (busy === 1'b1 && n < 50000) begin
      @(negedge clk);
      n++;
    end
    chk(24'(busy_cycles), 24'(`MMA_WORDS), "sweep length");
    @(negedge clk);
    chk({23'h0, landed}, 24'h000001, "not landed");
    repeat (40) @(negedge clk);
    chk({23'h0, fifo_ready}, 24'h000001, "buffer not drained");
  endtask : do_pulse
  // values straight after reset
  task automatic t_reset();
    chk({20'h0, fifo_ready, busy, landed, border_on}, 24'h000008, "reset outputs");
    chk(mword, 24'h000000, "reset mirror word");
    $display("test reset done");
  endtask : t_reset
  // load two columns, one bad select between, then land
  task automatic t_first();
    logic [23:0] v;
    load_col(5, 1);
    model_u.send_cmd({`MMA_OP_COL, 4'h0, 10'h3FF & 10'(`MMA_COLS - 1)});
    model_u.send_cmd({`MMA_OP_COL, 4'h0, 10'(`MMA_COLS)});
    for (int w = 0; w < `MMA_WPC; w++) begin
      model_u.send_word(pat(`MMA_COLS - 1, w, 2));
    end
    probe(5, 0, v);
    chk(v, 24'h000000, "parked readback");
    do_pulse(1'b0);
    chk_col(5, 1);
    chk_col(`MMA_COLS - 1, 2);
    $display("test first landing done");
  endtask : t_first
  // rewrite one column, mirrors hold until the pulse, others keep
  task automatic t_second();
    logic [23:0] v;
    load_col(5, 3);
    probe(5, 3, v);
    chk(v, pat(5, 3, 1), "mirror moved early");
    do_pulse(1'b1);
    chk_col(5, 3);
    chk_col(`MMA_COLS - 1, 2);
    $display("test second landing done");
  endtask : t_second
  // park: no held position
  task automatic t_park();
    logic [23:0] v;
    // 15 bits that would read as a pulse if the bit count went unchecked
    model_u.send_bits(16'h8000, 15);
    repeat (4) @(negedge clk);
    chk({23'h0, busy}, 24'h000000, "short frame acted");
    model_u.send_cmd({`MMA_OP_PARK, 14'h0000});
    repeat (6) @(negedge clk);
    probe(5, 0, v);
    chk(v, 24'h000000, "parked readback");
    chk({22'h0, landed, border_on}, 24'h000000, "park outputs");
    $display("test park done");
  endtask : t_park
  // print counts and the verdict, then stop
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  // main sequence
  initial begin
    arst_n = 1'b0;
    pcol = 10'h000;
    pword = 6'h00;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    t_reset();
    t_first();
    t_second();
    t_park();
    give_verdict();
  end
  // watchdog sized for two sweeps and the loads
  initial begin
    #(95000 * 4);
    n_fail++;
    give_verdict();
  end
endmodule : micromirror_array_memory_loader_bench
